// ### rtl/plb_phy_regs.sv
// PHY vendor register bank: loopback, error codes, status and 10BaseT control
//
// Operation
// R1: Loopback field 00 normal, 01 PMD loopback with pin, 10 remote, 11 reserved.
// R2: Upper loopback bit at 18.9 is writable and resets to zero.
// R3: Carrier select set: transmit asserts CRS in full duplex; clear: receive.
// R4: Code-error select picks 5h or generic 6h on receive nibble.
// R5: Premature-end select picks 4h or generic 6h on receive nibble.
// R6: Link-error select picks 3h or generic 6h on receive nibble.
// R7: Frame-error select picks 2h or generic 6h on receive nibble.
// R8: Descrambler timeout expiry is reported as a frame error.
// R9: Timeout is 722 us with select clear, 2000 us with it set.
// R10: Far-end fault enable is writable, resets zero, enables the function.
// R11: Duplex status bit is read-only, resets zero, shows link duplex.
// R12: Speed status reads 1 for 10BaseT, 0 for 100BaseTx.
// R13: Connection status bit shows the disconnect function state.
// R14: Address field 4:0 returns management address caught from straps.
// R15: Serial-mode bit is writable, resets from its strap pin; the code resets it to zero and loads the strap on the first edge after release.
// R16: Polarity state bit is read-only, resets zero, shows receive polarity.
// R17: Link pulse enable resets one, gates normal pulses, not FLP bursts.
// R18: Heartbeat enable resets one and switches heartbeat on or off.
// R19: Driver select resets one: 1 voltage-mode, 0 current-mode output.
// R20: Low squelch select is read/write, resets zero, has no effect.
// R21: Polarity correction control: 0 enables, 1 disables correction.
// R22: Jabber enable resets one and switches jabber protection.
// R23: Combined 100BaseTx transmit and receive latency stays within 170 ns.
// R24: Writes to read-only fields ignored; reserved loopback acts as normal.
`timescale 1ns/100ps
`default_nettype none

module plb_phy_regs (
  input wire logic clk_sys,
  input wire logic resetn,
  // Management register port
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRvalid,
  // Straps, sampled on the first edge after reset release
  input wire logic [4:0] strapAddress,
  input wire logic strapSerialMode,
  // Link state from the PHY core
  input wire logic linkFullDuplex,
  input wire logic linkTenBase,
  input wire logic linkConnected,
  input wire logic rxPolarityInverted,
  input wire logic tenBaseActive,
  // Receive path error events and data
  input wire logic rxActive,
  input wire logic txActive,
  input wire logic [3:0] rxNibbleIn,
  input wire logic rxDataValidIn,
  input wire logic rxCodeErr,
  input wire logic rxPrematureErr,
  input wire logic rxLinkErr,
  input wire logic descramblerLocked,
  input wire logic descramblerTimeoutDisable,
  input wire logic autoNegFlpBurst,
  input wire logic normalLinkPulseReq,
  // Control outputs
  output logic [3:0] rxNibbleOut,
  output logic rxDataValidOut,
  output logic rxErrorOut,
  output logic carrierSense,
  output logic loopbackIndicatorPin,
  output logic pmdLoopback,
  output logic remoteLoopback,
  output logic farEndFaultEnable,
  output logic tenBaseSerialMode,
  output logic linkPulseOut,
  output logic heartbeatEnable,
  output logic voltageModeOutput,
  output logic currentModeOutput,
  output logic polarityCorrectionEnable,
  output logic jabberEnable,
  input wire logic descramblerTimeoutSelect
);

  logic [1:0] loopbackSel_ff;
  logic fdCarrierSel_ff;
  logic [3:0] errSel_ff;
  logic farEndFault_ff;
  logic [4:0] mgmtAddr_ff;
  logic serialMode_ff;
  logic strapDone_ff;
  logic linkPulseEn_ff;
  logic heartbeat_ff;
  logic driverSel_ff;
  logic lowSquelch_ff;
  logic polarityCtl_ff;
  logic jabber_ff;
  logic duplexSt_ff;
  logic speedSt_ff;
  logic connSt_ff;
  logic polaritySt_ff;
  logic [17:0] toCnt_ff;
  logic frameErr;
  logic [15:0] nxt_rdata;
  logic [3:0] nxt_nibble;
  plb_pkg::plb_loopback_t lbMode;

  // Loopback field; upper bit writable, both reset to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loopbackSel_ff <= plb_pkg::LOOPBACK_RESET; // [R2]
      fdCarrierSel_ff <= plb_pkg::CTRL_CLEAR_RESET;
      errSel_ff <= 4'h0;
    end else if (regWrite &&
                 regAddr == plb_pkg::LOOPBACK_BYPASS_CONTROL_ADDR) begin
      loopbackSel_ff <= regWdata[plb_pkg::LOOPBACK_SELECT_HIGH_BIT:
                                 plb_pkg::LOOPBACK_SELECT_LOW_BIT]; // [R2]
      fdCarrierSel_ff <= regWdata[plb_pkg::FULL_DUPLEX_CARRIER_SELECT_BIT];
      errSel_ff <= regWdata[plb_pkg::CODE_ERROR_SELECT_BIT:
                            plb_pkg::FRAME_ERROR_SELECT_BIT];
    end
  end

  // Far-end fault enable is the only writable bit here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      farEndFault_ff <= plb_pkg::CTRL_CLEAR_RESET; // [R10]
    end else if (regWrite && regAddr == plb_pkg::PHY_ADDRESS_STATUS_ADDR) begin
      farEndFault_ff <= regWdata[plb_pkg::FAR_END_FAULT_ENABLE_BIT]; // [R10]
    end
  end

  // Straps caught once after release; reset cannot load a port value
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strapDone_ff <= 1'b0;
      mgmtAddr_ff <= 5'h00;
      serialMode_ff <= 1'b0;
    end else begin
      strapDone_ff <= 1'b1;
      if (!strapDone_ff) begin
        mgmtAddr_ff <= strapAddress; // [R14]
        serialMode_ff <= strapSerialMode; // [R15]
      end else if (regWrite && regAddr == plb_pkg::TENBASE_STATUS_ADDR) begin
        serialMode_ff <= regWdata[plb_pkg::TENBASE_SERIAL_MODE_BIT]; // [R15]
      end
    end
  end

  // 10BaseT transceiver controls
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      linkPulseEn_ff <= plb_pkg::TENBASE_ENABLE_RESET; // [R17]
      heartbeat_ff <= plb_pkg::TENBASE_ENABLE_RESET; // [R18]
      driverSel_ff <= plb_pkg::TENBASE_ENABLE_RESET; // [R19]
      lowSquelch_ff <= plb_pkg::CTRL_CLEAR_RESET; // [R20]
      polarityCtl_ff <= plb_pkg::CTRL_CLEAR_RESET; // [R21]
      jabber_ff <= plb_pkg::TENBASE_ENABLE_RESET; // [R22]
    end else if (regWrite && regAddr == plb_pkg::TENBASE_CONTROL_ADDR) begin
      linkPulseEn_ff <= regWdata[plb_pkg::LINK_PULSE_OUTPUT_ENABLE_BIT];
      heartbeat_ff <= regWdata[plb_pkg::HEARTBEAT_ENABLE_BIT];
      driverSel_ff <= regWdata[plb_pkg::OUTPUT_DRIVER_SELECT_BIT];
      lowSquelch_ff <= regWdata[plb_pkg::LOW_SQUELCH_SELECT_BIT]; // [R20]
      polarityCtl_ff <= regWdata[plb_pkg::POLARITY_CORRECTION_CONTROL_BIT];
      jabber_ff <= regWdata[plb_pkg::JABBER_ENABLE_BIT];
    end
  end

  // Status snapshots; software writes never reach these
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      duplexSt_ff <= 1'b0;
      speedSt_ff <= 1'b0;
      connSt_ff <= 1'b0;
      polaritySt_ff <= 1'b0;
    end else begin
      duplexSt_ff <= linkFullDuplex; // [R11] [R24]
      speedSt_ff <= linkTenBase; // [R12]
      connSt_ff <= linkConnected; // [R13]
      polaritySt_ff <= rxPolarityInverted; // [R16]
    end
  end

  // Descrambler timeout counter; restarts whenever lock is seen
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      toCnt_ff <= 18'h00000;
    end else if (descramblerLocked || descramblerTimeoutDisable ||
                 !rxActive) begin
      toCnt_ff <= 18'h00000;
    end else if (!frameErr) begin
      toCnt_ff <= toCnt_ff + 18'h00001;
    end
  end

  // Expiry at the selected length is the frame error
  assign frameErr = toCnt_ff >= (descramblerTimeoutSelect ?
                    18'(plb_pkg::TIMEOUT_LONG_CYC) :
                    18'(plb_pkg::TIMEOUT_SHORT_CYC)); // [R9] [R8]

  // Reserved code decodes as normal
  assign lbMode = plb_pkg::plb_loopback_t'(loopbackSel_ff);

  // Error nibble select; code error has highest priority
  always_comb begin
    nxt_nibble = rxNibbleIn;
    if (rxCodeErr) begin
      nxt_nibble = errSel_ff[3] ? plb_pkg::CODE_ERR_NIBBLE
                                : plb_pkg::GENERIC_ERR_NIBBLE; // [R4]
    end else if (rxPrematureErr) begin
      nxt_nibble = errSel_ff[2] ? plb_pkg::PREMATURE_ERR_NIBBLE
                                : plb_pkg::GENERIC_ERR_NIBBLE; // [R5]
    end else if (rxLinkErr) begin
      nxt_nibble = errSel_ff[1] ? plb_pkg::LINK_ERR_NIBBLE
                                : plb_pkg::GENERIC_ERR_NIBBLE; // [R6]
    end else if (frameErr) begin
      nxt_nibble = errSel_ff[0] ? plb_pkg::FRAME_ERR_NIBBLE
                                : plb_pkg::GENERIC_ERR_NIBBLE; // [R7] [R8]
    end
  end

  // One register stage keeps latency well inside the 170 ns budget
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxNibbleOut <= 4'h0;
      rxDataValidOut <= 1'b0;
      rxErrorOut <= 1'b0;
    end else begin
      rxNibbleOut <= nxt_nibble; // [R23]
      rxDataValidOut <= rxDataValidIn;
      rxErrorOut <= rxCodeErr | rxPrematureErr | rxLinkErr | frameErr;
    end
  end

  // Carrier sense and pin-level controls
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      carrierSense <= 1'b0;
      loopbackIndicatorPin <= 1'b0;
      pmdLoopback <= 1'b0;
      remoteLoopback <= 1'b0;
      linkPulseOut <= 1'b0;
    end else begin
      if (linkFullDuplex) begin
        carrierSense <= fdCarrierSel_ff ? txActive : rxActive; // [R3]
      end else begin
        carrierSense <= txActive | rxActive;
      end
      unique case (lbMode)
        plb_pkg::PLB_LB_PMD: begin
          loopbackIndicatorPin <= 1'b1; // [R1]
          pmdLoopback <= 1'b1;
          remoteLoopback <= 1'b0;
        end
        plb_pkg::PLB_LB_REMOTE: begin
          loopbackIndicatorPin <= 1'b0; // [R1]
          pmdLoopback <= 1'b0;
          remoteLoopback <= 1'b1;
        end
        plb_pkg::PLB_LB_NORMAL, plb_pkg::PLB_LB_RESERVED: begin
          loopbackIndicatorPin <= 1'b0; // [R1] [R24]
          pmdLoopback <= 1'b0;
          remoteLoopback <= 1'b0;
        end
      endcase
      // FLP bursts bypass the enable
      linkPulseOut <= autoNegFlpBurst |
                      (tenBaseActive & linkPulseEn_ff &
                       normalLinkPulseReq); // [R17]
    end
  end

  // Registered copies of control bits for the transceiver
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      farEndFaultEnable <= 1'b0;
      tenBaseSerialMode <= 1'b0;
      heartbeatEnable <= 1'b0;
      voltageModeOutput <= 1'b0;
      currentModeOutput <= 1'b0;
      polarityCorrectionEnable <= 1'b0;
      jabberEnable <= 1'b0;
    end else begin
      farEndFaultEnable <= farEndFault_ff; // [R10]
      tenBaseSerialMode <= serialMode_ff; // [R15]
      heartbeatEnable <= heartbeat_ff; // [R18]
      voltageModeOutput <= driverSel_ff; // [R19]
      currentModeOutput <= ~driverSel_ff; // [R19]
      polarityCorrectionEnable <= ~polarityCtl_ff; // [R21]
      jabberEnable <= jabber_ff; // [R22]
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (regAddr)
      plb_pkg::LOOPBACK_BYPASS_CONTROL_ADDR: begin
        nxt_rdata[plb_pkg::LOOPBACK_SELECT_HIGH_BIT:
                  plb_pkg::LOOPBACK_SELECT_LOW_BIT] = loopbackSel_ff;
        nxt_rdata[plb_pkg::FULL_DUPLEX_CARRIER_SELECT_BIT] = fdCarrierSel_ff;
        nxt_rdata[plb_pkg::CODE_ERROR_SELECT_BIT:
                  plb_pkg::FRAME_ERROR_SELECT_BIT] = errSel_ff;
      end
      plb_pkg::PHY_ADDRESS_STATUS_ADDR: begin
        nxt_rdata[plb_pkg::FAR_END_FAULT_ENABLE_BIT] = farEndFault_ff;
        nxt_rdata[plb_pkg::DUPLEX_STATUS_BIT] = duplexSt_ff; // [R11]
        nxt_rdata[plb_pkg::SPEED_STATUS_BIT] = speedSt_ff; // [R12]
        nxt_rdata[plb_pkg::CONNECTION_STATUS_BIT] = connSt_ff; // [R13]
        nxt_rdata[plb_pkg::MANAGEMENT_ADDRESS_LSB +: 5] = mgmtAddr_ff; // [R14]
      end
      plb_pkg::TENBASE_STATUS_ADDR: begin
        nxt_rdata[plb_pkg::TENBASE_SERIAL_MODE_BIT] = serialMode_ff;
        nxt_rdata[plb_pkg::POLARITY_STATE_BIT] = polaritySt_ff; // [R16]
      end
      plb_pkg::TENBASE_CONTROL_ADDR: begin
        nxt_rdata[plb_pkg::LINK_PULSE_OUTPUT_ENABLE_BIT] = linkPulseEn_ff;
        nxt_rdata[plb_pkg::HEARTBEAT_ENABLE_BIT] = heartbeat_ff;
        nxt_rdata[plb_pkg::OUTPUT_DRIVER_SELECT_BIT] = driverSel_ff;
        nxt_rdata[plb_pkg::LOW_SQUELCH_SELECT_BIT] = lowSquelch_ff; // [R20]
        nxt_rdata[plb_pkg::POLARITY_CORRECTION_CONTROL_BIT] = polarityCtl_ff;
        nxt_rdata[plb_pkg::JABBER_ENABLE_BIT] = jabber_ff;
      end
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= nxt_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/plb_pkg.sv
// Register map, field positions, reset values and timing counts of the PHY bank
package plb_pkg;
  // Register addresses on the management port
  localparam logic [4:0] LOOPBACK_BYPASS_CONTROL_ADDR = 5'h18;
  localparam logic [4:0] PHY_ADDRESS_STATUS_ADDR = 5'h19;
  localparam logic [4:0] TENBASE_STATUS_ADDR = 5'h1b;
  localparam logic [4:0] TENBASE_CONTROL_ADDR = 5'h1c;
  // Field positions in loopback_bypass_control
  localparam int LOOPBACK_SELECT_HIGH_BIT = 9;
  localparam int LOOPBACK_SELECT_LOW_BIT = 8;
  localparam int FULL_DUPLEX_CARRIER_SELECT_BIT = 6;
  localparam int CODE_ERROR_SELECT_BIT = 4;
  localparam int PREMATURE_END_ERROR_SELECT_BIT = 3;
  localparam int LINK_ERROR_SELECT_BIT = 2;
  localparam int FRAME_ERROR_SELECT_BIT = 1;
  // Field positions in phy_address_status
  localparam int FAR_END_FAULT_ENABLE_BIT = 8;
  localparam int DUPLEX_STATUS_BIT = 7;
  localparam int SPEED_STATUS_BIT = 6;
  localparam int CONNECTION_STATUS_BIT = 5;
  localparam int MANAGEMENT_ADDRESS_LSB = 0;
  // Field positions in tenbase_status and tenbase_control
  localparam int TENBASE_SERIAL_MODE_BIT = 9;
  localparam int POLARITY_STATE_BIT = 0;
  localparam int LINK_PULSE_OUTPUT_ENABLE_BIT = 5;
  localparam int HEARTBEAT_ENABLE_BIT = 4;
  localparam int OUTPUT_DRIVER_SELECT_BIT = 3;
  localparam int LOW_SQUELCH_SELECT_BIT = 2;
  localparam int POLARITY_CORRECTION_CONTROL_BIT = 1;
  localparam int JABBER_ENABLE_BIT = 0;
  // Reset values of writable control bits
  localparam logic [1:0] LOOPBACK_RESET = 2'h0;
  localparam logic CTRL_CLEAR_RESET = 1'b0;
  localparam logic TENBASE_ENABLE_RESET = 1'b1;
  // Receive nibble error codes
  localparam logic [3:0] CODE_ERR_NIBBLE = 4'h5;
  localparam logic [3:0] PREMATURE_ERR_NIBBLE = 4'h4;
  localparam logic [3:0] LINK_ERR_NIBBLE = 4'h3;
  localparam logic [3:0] FRAME_ERR_NIBBLE = 4'h2;
  localparam logic [3:0] GENERIC_ERR_NIBBLE = 4'h6;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_SHORT_US = 722;
  localparam int TIMEOUT_LONG_US = 2000;
  localparam int LATENCY_MAX_NS = 170;
  localparam int TIMEOUT_SHORT_CYC = TIMEOUT_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_LONG_CYC = TIMEOUT_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int LATENCY_MAX_CYC = LATENCY_MAX_NS / CLK_PERIOD_NS;
  // Loopback modes
  typedef enum logic [1:0] {
    PLB_LB_NORMAL,
    PLB_LB_PMD,
    PLB_LB_REMOTE,
    PLB_LB_RESERVED
  } plb_loopback_t;
endpackage

// ### sim/plb_phy_regs_properties.sv
// Checker of the PHY register bank port behaviour
`timescale 1ns/100ps
`default_nettype none
module plb_phy_regs_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic linkFullDuplex,
  input wire logic linkTenBase,
  input wire logic rxActive,
  input wire logic txActive,
  input wire logic rxCodeErr,
  input wire logic [3:0] rxNibbleOut,
  input wire logic rxErrorOut,
  input wire logic carrierSense,
  input wire logic pmdLoopback,
  input wire logic remoteLoopback,
  input wire logic loopbackIndicatorPin,
  input wire logic voltageModeOutput,
  input wire logic currentModeOutput
);
  logic [1:0] lbSel_ff;
  logic fdSel_ff;
  logic codeSel_ff;
  logic lbWr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Write strobe aimed at the loopback register
  assign lbWr = regWrite && (regAddr == plb_pkg::LOOPBACK_BYPASS_CONTROL_ADDR);
  // Shadow of the loopback, carrier and code-error select fields, so expectations never read the design
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lbSel_ff <= 2'h0;
      fdSel_ff <= 1'b0;
      codeSel_ff <= 1'b0;
    end else if (lbWr) begin
      lbSel_ff <= regWdata[9:8];
      fdSel_ff <= regWdata[6];
      codeSel_ff <= regWdata[4];
    end
  end
  unmapped_zero_a: assert property (
    regRead && !(regAddr inside {5'h18, 5'h19, 5'h1b, 5'h1c})
    |=> regRdata == 16'h0000)
    else $error("unmapped read returned nonzero data");
  code_nibble_a: assert property (
    rxCodeErr |=> rxErrorOut
    && rxNibbleOut == ($past(codeSel_ff) ? 4'h5 : 4'h6))
    else $error("code error nibble wrong");
  lb_modes_a: assert property (
    $stable(lbSel_ff)[*3] |-> pmdLoopback == (lbSel_ff == 2'h1)
    && loopbackIndicatorPin == (lbSel_ff == 2'h1)
    && remoteLoopback == (lbSel_ff == 2'h2))
    else $error("loopback outputs disagree with selection");
  lb_reserved_a: assert property (
    (lbSel_ff == 2'h3)[*3] |-> !pmdLoopback && !remoteLoopback
    && !loopbackIndicatorPin)
    else $error("reserved loopback code not treated as normal");
  crs_tx_only_a: assert property (
    (linkFullDuplex && txActive && !rxActive && fdSel_ff)[*3]
    |-> carrierSense)
    else $error("carrier sense missing on transmit");
  crs_rx_only_a: assert property (
    (linkFullDuplex && txActive && !rxActive && !fdSel_ff)[*3]
    |-> !carrierSense)
    else $error("carrier sense raised by transmit");
  driver_excl_a: assert property (
    $past(resetn, 2) |-> voltageModeOutput != currentModeOutput)
    else $error("output driver modes not exclusive");
  speed_read_a: assert property (
    regRead && regAddr == 5'h19 && $stable(linkTenBase) && $past(resetn)
    |=> regRdata[6] == $past(linkTenBase))
    else $error("speed status bit wrong");
endmodule
bind plb_phy_regs plb_phy_regs_properties i_props (
  .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
  .regRdata(regRdata), .linkFullDuplex(linkFullDuplex),
  .linkTenBase(linkTenBase), .rxActive(rxActive), .txActive(txActive),
  .rxCodeErr(rxCodeErr), .rxNibbleOut(rxNibbleOut),
  .rxErrorOut(rxErrorOut), .carrierSense(carrierSense),
  .pmdLoopback(pmdLoopback), .remoteLoopback(remoteLoopback),
  .loopbackIndicatorPin(loopbackIndicatorPin),
  .voltageModeOutput(voltageModeOutput),
  .currentModeOutput(currentModeOutput)
);
`default_nettype wire

// ### sim/plb_mgmt_model.sv
// Station manager model issuing accesses on the management register port
`timescale 1ns/100ps
`default_nettype none
module plb_mgmt_model (
  input wire logic clk_sys,
  output var logic [4:0] regAddr,
  output var logic regWrite,
  output var logic regRead,
  output var logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid
);
  // Port idle at time zero
  initial begin
    regAddr = 5'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
  end
  // Data is inverted once released, so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  // Answer taken in the one cycle that it stands
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdata;
    v = regRvalid;
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench of the PHY register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys, resetn, regWrite, regRead, regRvalid, strapSerialMode;
  logic [4:0] regAddr, strapAddress;
  logic [15:0] regWdata, regRdata, rdv;
  logic linkFullDuplex, linkTenBase, linkConnected, rxPolarityInverted;
  logic tenBaseActive, rxActive, txActive, rxDataValidIn, vld;
  logic rxCodeErr, rxPrematureErr, rxLinkErr, descramblerLocked;
  logic descramblerTimeoutDisable, autoNegFlpBurst, normalLinkPulseReq;
  logic descramblerTimeoutSelect, rxDataValidOut, rxErrorOut, carrierSense;
  logic [3:0] rxNibbleIn, rxNibbleOut;
  logic loopbackIndicatorPin, pmdLoopback, remoteLoopback, farEndFaultEnable;
  logic tenBaseSerialMode, linkPulseOut, heartbeatEnable, voltageModeOutput;
  logic currentModeOutput, polarityCorrectionEnable, jabberEnable;
  logic [6:0] tbOut;
  int fails, checks, n;
  // 10BaseT control outputs gathered for one comparison
  assign tbOut = {linkPulseOut, tenBaseSerialMode, heartbeatEnable,
    jabberEnable, voltageModeOutput, currentModeOutput,
    polarityCorrectionEnable};
  plb_phy_regs i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid),
    .strapAddress(strapAddress), .strapSerialMode(strapSerialMode),
    .linkFullDuplex(linkFullDuplex), .linkTenBase(linkTenBase),
    .linkConnected(linkConnected), .rxPolarityInverted(rxPolarityInverted),
    .tenBaseActive(tenBaseActive), .rxActive(rxActive), .txActive(txActive),
    .rxNibbleIn(rxNibbleIn), .rxDataValidIn(rxDataValidIn),
    .rxCodeErr(rxCodeErr), .rxPrematureErr(rxPrematureErr),
    .rxLinkErr(rxLinkErr), .descramblerLocked(descramblerLocked),
    .descramblerTimeoutDisable(descramblerTimeoutDisable),
    .autoNegFlpBurst(autoNegFlpBurst),
    .normalLinkPulseReq(normalLinkPulseReq), .rxNibbleOut(rxNibbleOut),
    .rxDataValidOut(rxDataValidOut), .rxErrorOut(rxErrorOut),
    .carrierSense(carrierSense), .loopbackIndicatorPin(loopbackIndicatorPin),
    .pmdLoopback(pmdLoopback), .remoteLoopback(remoteLoopback),
    .farEndFaultEnable(farEndFaultEnable),
    .tenBaseSerialMode(tenBaseSerialMode), .linkPulseOut(linkPulseOut),
    .heartbeatEnable(heartbeatEnable), .voltageModeOutput(voltageModeOutput),
    .currentModeOutput(currentModeOutput),
    .polarityCorrectionEnable(polarityCorrectionEnable),
    .jabberEnable(jabberEnable),
    .descramblerTimeoutSelect(descramblerTimeoutSelect)
  );
  plb_mgmt_model i_mgr (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid)
  );
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // A read without its valid pulse counts as wrong data
  task automatic rchk(input string name, input logic [4:0] a,
                      input logic [15:0] e);
    i_mgr.rd(a, rdv, vld);
    chk(name, e, vld === 1'b1 ? rdv : 16'hxxxx);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bound just past the short descrambler wait, short of the long one
  initial begin
    #(85000 * 10);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial begin
    fails = 0;
    checks = 0;
    resetn = 1'b0;
    strapAddress = 5'h0b;
    strapSerialMode = 1'b1;
    rxNibbleIn = 4'h0;
    descramblerLocked = 1'b1;
    {linkFullDuplex, linkTenBase, linkConnected, rxPolarityInverted} = 4'h0;
    {rxActive, txActive, rxDataValidIn, rxCodeErr} = 4'h0;
    {rxPrematureErr, rxLinkErr, descramblerTimeoutDisable} = 3'h0;
    {autoNegFlpBurst, descramblerTimeoutSelect} = 2'h0;
    {tenBaseActive, normalLinkPulseReq} = 2'h3;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rchk("loopback reset", 5'h18, 16'h0000);
    rchk("address reset", 5'h19, 16'h000b);
    rchk("tenbase status reset", 5'h1b, 16'h0200);
    rchk("tenbase control reset", 5'h1c, 16'h0039);
    rchk("unmapped read", 5'h1a, 16'h0000);
    chk("tenbase outputs reset", 16'h007d, {9'h000, tbOut});
    i_mgr.wr(5'h1c, 16'h0006);
    settle();
    chk("tenbase outputs", 16'h0022, {9'h000, tbOut});
    rchk("tenbase control", 5'h1c, 16'h0006);
    autoNegFlpBurst <= 1'b1;
    settle();
    chk("flp burst", 16'h0001, {15'h0000, linkPulseOut});
    autoNegFlpBurst <= 1'b0;
    for (n = 0; n < 4; n++) begin
      i_mgr.wr(5'h18, {6'h00, n[1:0], 8'h00});
      settle();
      chk("loopback outputs", {13'h0000, n == 1, n == 2, n == 1},
        {13'h0000, pmdLoopback, remoteLoopback, loopbackIndicatorPin});
      rchk("loopback readback", 5'h18, {6'h00, n[1:0], 8'h00});
    end
    i_mgr.wr(5'h19, 16'hffff);
    {linkFullDuplex, linkTenBase, linkConnected, rxPolarityInverted} <= 4'hf;
    settle();
    chk("far end fault", 16'h0001, {15'h0000, farEndFaultEnable});
    rchk("address status", 5'h19, 16'h01eb);
    rchk("polarity state", 5'h1b, 16'h0201);
    i_mgr.wr(5'h19, 16'h0000);
    {linkFullDuplex, linkTenBase, linkConnected, rxPolarityInverted} <= 4'h0;
    for (n = 0; n < 6; n++) begin
      i_mgr.wr(5'h18, n[0] ? 16'h001c : 16'h0000);
      settle();
      @(posedge clk_sys);
      {rxCodeErr, rxPrematureErr, rxLinkErr} <= 3'h4 >> (n / 2);
      @(posedge clk_sys);
      {rxCodeErr, rxPrematureErr, rxLinkErr} <= 3'h0;
      #1;
      chk("error nibble", {11'h000, 1'b1, n[0] ? 4'h5 - 4'(n / 2) : 4'h6},
        {11'h000, rxErrorOut, rxNibbleOut});
    end
    {linkFullDuplex, txActive} <= 2'h3;
    i_mgr.wr(5'h18, 16'h0040);
    settle();
    chk("crs on transmit", 16'h0001, {15'h0000, carrierSense});
    i_mgr.wr(5'h18, 16'h0000);
    settle();
    chk("crs ignores transmit", 16'h0000, {15'h0000, carrierSense});
    {txActive, rxActive} <= 2'h1;
    settle();
    chk("crs on receive", 16'h0001, {15'h0000, carrierSense});
    rxNibbleIn <= 4'ha;
    rxDataValidIn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("rx latency", 16'h001a,
      {11'h000, rxDataValidOut, rxNibbleOut});
    i_mgr.wr(5'h18, 16'h0002);
    @(posedge clk_sys);
    descramblerLocked <= 1'b0;
    n = 0;
    while (rxErrorOut !== 1'b1 && n < 80000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("timeout length", 16'h0001, {15'h0000,
      n >= plb_pkg::TIMEOUT_SHORT_CYC - 5 &&
      n <= plb_pkg::TIMEOUT_SHORT_CYC + 5});
    chk("frame error nibble", 16'h0002, {12'h000, rxNibbleOut});
    descramblerTimeoutSelect <= 1'b1;
    settle();
    chk("long timeout select", 16'h0000, {15'h0000, rxErrorOut});
    give_verdict();
  end
endmodule
`default_nettype wire
